// [rtl/tpg_gpio.sv]
// Two-port general I/O block with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite interface to the registers.
module tpg_gpio #(
   parameter int ADDR_W = 18
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] p1_pin_in,
   output logic [7:0] p1_pin_out,
   output logic [7:0] p1_pin_oe,
   output logic [7:0] p1_pullup,
   input wire logic [7:0] p2_pin_in,
   output logic [7:0] p2_pin_out,
   output logic [7:0] p2_pin_oe,
   output logic [7:0] p2_pullup,
   input wire logic timer_f_high,
   input wire logic timer_f_low,
   input wire logic clock_out_src,
   input wire logic [2:0] timer_f_clock_select,
   output logic ext_int_one_n,
   output logic ext_int_two_n,
   output logic ext_int_three_n,
   output logic timer_f_event_input,
   output logic timer_g_capture_input
);
   logic [7:0] port1_pin_mode;
   logic [7:0] port1_direction;
   logic [7:0] port1_output_data;
   logic [7:0] port1_pullup_enable;
   logic [7:0] port2_pin_mode;
   logic [7:0] port_serial_tx_mode;
   logic [7:0] port2_pullup_enable;
   logic [7:0] port2_output_data;
   logic [7:0] port2_direction;
   tpg_pkg::tpg_pwr_t power_mode;
   logic [7:0] p1_sync;
   logic [7:0] p2_sync;
   logic [7:0] next_p1_oe;
   logic [7:0] next_p1_out;
   logic aw_full;
   logic w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   logic do_write;
   logic [15:0] wr_idx;
   logic [15:0] rd_idx;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic wr_hit;

   //----------------------------------------------------------------
   // Helper functions
   //----------------------------------------------------------------
   // Word index of a byte address
   function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = 16'(addr[ADDR_W-1:2]);
   endfunction

   // Output pins give stored data, input pins give the live level
   function automatic logic [7:0] port_read(input logic [7:0] dir,
                                            input logic [7:0] data,
                                            input logic [7:0] pins);
      port_read = (dir & data) | (~dir & pins);
   endfunction

   // Pull-up is only meaningful on a pin set as input
   function automatic logic [7:0] pull_on(input logic [7:0] dir,
                                          input logic [7:0] pu);
      pull_on = ~dir & pu;
   endfunction

   // Address decode shared by read and write paths
   function automatic logic idx_valid(input logic [15:0] idx);
      idx_valid = (idx == tpg_pkg::IDX_P1_MODE) || (idx == tpg_pkg::IDX_P2_MODE) ||
                  (idx == tpg_pkg::IDX_P6_MODE) || (idx == tpg_pkg::IDX_P1_PU) ||
                  (idx == tpg_pkg::IDX_P2_PU) || (idx == tpg_pkg::IDX_P1_DATA) ||
                  (idx == tpg_pkg::IDX_P2_DATA) || (idx == tpg_pkg::IDX_P1_DIR) ||
                  (idx == tpg_pkg::IDX_P2_DIR) || (idx == tpg_pkg::IDX_PWR);
   endfunction

   //----------------------------------------------------------------
   // Pin input synchronisers and port 1 function select
   //----------------------------------------------------------------
   tpg_sync #(
      .W(16)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({p2_pin_in, p1_pin_in}),
      .sync_out({p2_sync, p1_sync})
   );

   tpg_p1_mux u_mux (
      .pin_mode(port1_pin_mode),
      .direction(port1_direction),
      .out_data(port1_output_data),
      .timer_f_high(timer_f_high),
      .timer_f_low(timer_f_low),
      .clock_out_src(clock_out_src),
      .next_oe(next_p1_oe),
      .next_out(next_p1_out)
   );

   //----------------------------------------------------------------
   // AXI4-Lite write channel
   //----------------------------------------------------------------
   assign s_axi_awready = !aw_full;
   assign s_axi_wready = !w_full;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign wr_idx = reg_index(aw_addr);
   assign wr_hit = idx_valid(wr_idx);

   // Address and data are held separately so either may come first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_byte <= '0;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_byte <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_full <= 1'b0;
      end
   end

   // Unmapped writes are dropped and answered with an error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tpg_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------
   // Only byte lane 0 carries register data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port1_pin_mode <= tpg_pkg::RST_ZERO;
         port1_direction <= tpg_pkg::RST_ZERO;
         port1_output_data <= tpg_pkg::RST_ZERO;
         port1_pullup_enable <= tpg_pkg::RST_ZERO;
         port2_pin_mode <= tpg_pkg::RST_P2_MODE;
         port_serial_tx_mode <= tpg_pkg::RST_P6_MODE;
         port2_pullup_enable <= tpg_pkg::RST_ZERO;
         port2_output_data <= tpg_pkg::RST_ZERO;
         port2_direction <= tpg_pkg::RST_ZERO;
         power_mode <= tpg_pkg::PWR_ACTIVE;
      end else if (do_write && w_lane0) begin
         unique case (wr_idx)
            tpg_pkg::IDX_P1_MODE: port1_pin_mode <= w_byte & tpg_pkg::P1_MODE_WMASK;
            tpg_pkg::IDX_P1_DIR: port1_direction <= w_byte;
            tpg_pkg::IDX_P1_DATA: port1_output_data <= w_byte;
            tpg_pkg::IDX_P1_PU: port1_pullup_enable <= w_byte;
            tpg_pkg::IDX_P2_MODE: begin
               port2_pin_mode <= (w_byte & tpg_pkg::P2_MODE_WMASK) | tpg_pkg::P2_MODE_ONES;
            end
            tpg_pkg::IDX_P6_MODE: begin
               port_serial_tx_mode <= (w_byte & tpg_pkg::P6_MODE_WMASK) | tpg_pkg::P6_MODE_ONES;
            end
            tpg_pkg::IDX_P2_PU: port2_pullup_enable <= w_byte;
            tpg_pkg::IDX_P2_DATA: port2_output_data <= w_byte;
            tpg_pkg::IDX_P2_DIR: port2_direction <= w_byte;
            tpg_pkg::IDX_PWR: power_mode <= tpg_pkg::tpg_pwr_t'(w_byte[5:0]);
            default: ;
         endcase
      end
   end

   //----------------------------------------------------------------
   // AXI4-Lite read channel
   //----------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_idx = reg_index(s_axi_araddr);
   assign rd_hit = idx_valid(rd_idx);

   // Read mux; write-only direction registers read as all ones
   always_comb begin
      unique case (rd_idx)
         tpg_pkg::IDX_P1_MODE: rd_byte = port1_pin_mode;
         tpg_pkg::IDX_P1_DIR: rd_byte = tpg_pkg::DIR_READ;
         tpg_pkg::IDX_P1_DATA: begin
            rd_byte = port_read(port1_direction, port1_output_data, p1_sync);
         end
         tpg_pkg::IDX_P1_PU: rd_byte = port1_pullup_enable;
         tpg_pkg::IDX_P2_MODE: rd_byte = port2_pin_mode;
         tpg_pkg::IDX_P6_MODE: rd_byte = port_serial_tx_mode;
         tpg_pkg::IDX_P2_PU: rd_byte = port2_pullup_enable;
         tpg_pkg::IDX_P2_DATA: begin
            rd_byte = port_read(port2_direction, port2_output_data, p2_sync);
         end
         tpg_pkg::IDX_P2_DIR: rd_byte = tpg_pkg::DIR_READ;
         tpg_pkg::IDX_PWR: rd_byte = {2'b00, power_mode};
         default: rd_byte = tpg_pkg::RST_ZERO;
      endcase
   end

   // Data is captured with the address, so a pin change after that is not seen
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= tpg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_hit ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // Pin drive: port 1 per operating mode, port 2 by direction alone
   //----------------------------------------------------------------
   // Reset floats everything; sleep modes freeze the last drive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p1_pin_oe <= '0;
         p1_pin_out <= '0;
         p1_pullup <= '0;
      end else begin
         unique case (power_mode)
            tpg_pkg::PWR_SLEEP, tpg_pkg::PWR_SUBSLEEP, tpg_pkg::PWR_WATCH: begin
               p1_pin_oe <= p1_pin_oe;
               p1_pin_out <= p1_pin_out;
               p1_pullup <= p1_pullup;
            end
            tpg_pkg::PWR_STANDBY: begin
               p1_pin_oe <= '0;
               p1_pin_out <= p1_pin_out;
               p1_pullup <= pull_on(port1_direction, port1_pullup_enable);
            end
            default: begin
               p1_pin_oe <= next_p1_oe;
               p1_pin_out <= next_p1_out;
               p1_pullup <= pull_on(port1_direction, port1_pullup_enable);
            end
         endcase
      end
   end

   // Port 2 follows direction; pin 7 never drives and has no pull-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p2_pin_oe <= '0;
         p2_pin_out <= '0;
         p2_pullup <= '0;
      end else begin
         p2_pin_oe <= port2_direction & tpg_pkg::P2_BIDIR;
         p2_pin_out <= port2_output_data & tpg_pkg::P2_BIDIR;
         p2_pullup <= pull_on(port2_direction, port2_pullup_enable) & tpg_pkg::P2_BIDIR;
      end
   end

   //----------------------------------------------------------------
   // Alternate inputs towards timers and interrupt logic
   //----------------------------------------------------------------
   // Deselected inputs idle high so no false active-low request appears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_int_one_n <= 1'b1;
         ext_int_two_n <= 1'b1;
         ext_int_three_n <= 1'b1;
         timer_f_event_input <= 1'b1;
         timer_g_capture_input <= 1'b1;
      end else begin
         ext_int_one_n <= port1_pin_mode[tpg_pkg::P1_INT1_BIT] ?
                          p1_sync[tpg_pkg::P1_INT1_BIT] : 1'b1;
         ext_int_two_n <= port1_pin_mode[tpg_pkg::P1_INT2_BIT] ?
                          p1_sync[tpg_pkg::P1_INT2_BIT] : 1'b1;
         ext_int_three_n <= port1_pin_mode[tpg_pkg::P1_INT3_BIT] ?
                            p1_sync[tpg_pkg::P1_INT3_BIT] : 1'b1;
         // Masking interrupt 3 in timer-event use is left to software
         timer_f_event_input <= (port1_pin_mode[tpg_pkg::P1_INT3_BIT] &&
                                 !timer_f_clock_select[tpg_pkg::CKSL_MSB]) ?
                                p1_sync[tpg_pkg::P1_INT3_BIT] : 1'b1;
         timer_g_capture_input <= port1_pin_mode[tpg_pkg::P1_TMG_BIT] ?
                                  p1_sync[tpg_pkg::P1_TMG_BIT] : 1'b1;
      end
   end

   //----------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------
   a_reset_float: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (p1_pin_oe == '0) && (p1_pullup == '0) && (port2_output_data == '0))
      else $error("pins or data not cleared by reset");

   a_pull_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
      (p1_pin_oe & p1_pullup & ~$past(port1_pin_mode)) == '0 || $past(power_mode) != tpg_pkg::PWR_ACTIVE)
      else $error("pull-up on a driving port 1 pin");

   a_pull_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      (power_mode == tpg_pkg::PWR_ACTIVE) |=>
      (p1_pullup == pull_on($past(port1_direction), $past(port1_pullup_enable))))
      else $error("pull-up does not follow direction and enable");

   a_standby_float: assert property (@(posedge aclk) disable iff (!aresetn)
      (power_mode == tpg_pkg::PWR_STANDBY) |=> (p1_pin_oe == '0))
      else $error("port 1 drives in standby");

   a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (power_mode inside {tpg_pkg::PWR_SLEEP, tpg_pkg::PWR_SUBSLEEP, tpg_pkg::PWR_WATCH}) |=>
      $stable(p1_pin_oe) && $stable(p1_pin_out) && $stable(p1_pullup))
      else $error("port 1 pins change in a retaining mode");

   a_alt_input: assert property (@(posedge aclk) disable iff (!aresetn)
      (power_mode == tpg_pkg::PWR_ACTIVE) |=>
      ((p1_pin_oe & $past(port1_pin_mode) & tpg_pkg::P1_ALT_IN) == '0))
      else $error("alternate input pin is driven");

   a_timer_out: assert property (@(posedge aclk) disable iff (!aresetn)
      (power_mode == tpg_pkg::PWR_ACTIVE && port1_pin_mode[tpg_pkg::P1_TFH_BIT]) |=>
      p1_pin_oe[tpg_pkg::P1_TFH_BIT] && (p1_pin_out[tpg_pkg::P1_TFH_BIT] == $past(timer_f_high)))
      else $error("timer F high output not on its pin");

   a_plain_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      (power_mode == tpg_pkg::PWR_ACTIVE) |=> (p1_pin_oe[4] == $past(port1_direction[4])))
      else $error("pin 4 drive does not follow direction");

   a_dir_ones: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rd_idx == tpg_pkg::IDX_P1_DIR) |=>
      s_axi_rvalid && (s_axi_rdata == 32'h0000_00ff))
      else $error("direction register does not read all ones");

   a_p2_input_only: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 !p2_pin_oe[7] && !p2_pullup[7])
      else $error("port 2 pin 7 is driven or pulled");

   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid ##0 (aw_full == 1'b0 || s_axi_awvalid))
      else $error("write not answered");
endmodule

// [inc/tpg_pkg.sv]
// Constants, register map and power modes of the two-port general I/O block
//----------------------------------------------------------------------------
// How it works
// - Pin 7 select bit picks general I/O or interrupt-3 input, also timer F event.
// - Pin 6 is general I/O by direction, or interrupt-2 input when selected.
// - Pin 5 is general I/O by direction, or interrupt-1 input when selected.
// - Pin 4 has no alternate use; direction bit alone sets in or out.
// - Pin 3 is general I/O by direction, or timer G capture input when selected.
// - Pins 2..0 drive timer F high, timer F low, clock out when selected.
// - Port 1 pins float in reset and standby, hold in sleep modes, work otherwise.
// - Standby floats port 1 pins; enabled pull-up presents high level.
// - Pull-up on only when direction is input and pull-up bit set; sleep modes hold the last pull-up state instead.
// - All port 1 pull-ups are off after reset.
// - Port 2 has seven two-way pins and one input-only pin.
// - Port 2 data read gives stored bit for outputs, pin level for inputs.
// - Reset clears port 2 data register to zero.
// - Direction 1 makes a general pin output, 0 input.
// - Port 1 direction register is write-only and reads all ones.
// - Port 1 data read gives stored bit for outputs, pin level for inputs.
//----------------------------------------------------------------------------
package tpg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_P1_MODE = 16'hff98;
   localparam logic [15:0] IDX_P2_MODE = 16'hff99;
   localparam logic [15:0] IDX_P6_MODE = 16'hff9a;
   localparam logic [15:0] IDX_P1_PU = 16'hff9c;
   localparam logic [15:0] IDX_P2_PU = 16'hff9d;
   localparam logic [15:0] IDX_P1_DATA = 16'hffd4;
   localparam logic [15:0] IDX_P2_DATA = 16'hffd5;
   localparam logic [15:0] IDX_P1_DIR = 16'hffe4;
   localparam logic [15:0] IDX_P2_DIR = 16'hffe5;
   localparam logic [15:0] IDX_PWR = 16'hfff0;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_P2_MODE = 8'h40;
   localparam logic [7:0] RST_P6_MODE = 8'hf8;
   localparam logic [7:0] DIR_READ = 8'hff;
   // Writable and fixed-one masks of mode registers
   localparam logic [7:0] P1_MODE_WMASK = 8'hef;
   localparam logic [7:0] P2_MODE_WMASK = 8'hbf;
   localparam logic [7:0] P2_MODE_ONES = 8'h40;
   localparam logic [7:0] P6_MODE_WMASK = 8'h37;
   localparam logic [7:0] P6_MODE_ONES = 8'hc8;
   // Port 1 alternate-function fields
   localparam logic [7:0] P1_ALT_IN = 8'he8;
   localparam logic [7:0] P1_ALT_OUT = 8'h07;
   localparam int P1_INT3_BIT = 7;
   localparam int P1_INT2_BIT = 6;
   localparam int P1_INT1_BIT = 5;
   localparam int P1_TMG_BIT = 3;
   localparam int P1_TFH_BIT = 2;
   localparam int P1_TFL_BIT = 1;
   localparam int P1_CKO_BIT = 0;
   localparam int CKSL_MSB = 2;
   // Port 2 pin 7 is input only
   localparam logic [7:0] P2_BIDIR = 8'h7f;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Operating modes, one-hot
   typedef enum logic [5:0] {
      PWR_ACTIVE = 6'b00_0001,
      PWR_SUBACTIVE = 6'b00_0010,
      PWR_SLEEP = 6'b00_0100,
      PWR_SUBSLEEP = 6'b00_1000,
      PWR_WATCH = 6'b01_0000,
      PWR_STANDBY = 6'b10_0000
   } tpg_pwr_t;
endpackage

// [rtl/tpg_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
module tpg_sync #(
   parameter int W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;

   //----------------------------------------------------------------
   // Stages
   //----------------------------------------------------------------
   // First stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// [rtl/tpg_p1_mux.sv]
// Port 1 pin function selection: drive enable and drive level per pin
module tpg_p1_mux (
   input wire logic [7:0] pin_mode,
   input wire logic [7:0] direction,
   input wire logic [7:0] out_data,
   input wire logic timer_f_high,
   input wire logic timer_f_low,
   input wire logic clock_out_src,
   output logic [7:0] next_oe,
   output logic [7:0] next_out
);
   logic [7:0] alt_in;
   logic [7:0] alt_out;
   logic [7:0] alt_level;

   //----------------------------------------------------------------
   // Selection
   //----------------------------------------------------------------
   // Reserved mode bit 4 is masked, so pin 4 stays pure I/O
   always_comb begin
      alt_in = pin_mode & tpg_pkg::P1_ALT_IN;
      alt_out = pin_mode & tpg_pkg::P1_ALT_OUT;
      alt_level = '0;
      alt_level[tpg_pkg::P1_TFH_BIT] = timer_f_high;
      alt_level[tpg_pkg::P1_TFL_BIT] = timer_f_low;
      alt_level[tpg_pkg::P1_CKO_BIT] = clock_out_src;
      // Direction only counts on pins left as general I/O
      next_oe = (direction & ~alt_in & ~alt_out) | alt_out;
      next_out = (out_data & ~alt_out) | (alt_level & alt_out);
   end
endmodule

// [testbench/tpg_pin_model.sv]
// Pin model: level of each port pin from block drive, pull-up and an outside driver
module tpg_pin_model (
   input wire logic aclk,
   input wire logic [7:0] oe,
   input wire logic [7:0] out,
   input wire logic [7:0] pu,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last;
   // A floating pin without pull-up wanders, so no test may lean on a stale level
   always_ff @(posedge aclk) begin
      last <= level;
   end
   // Block drive wins, then the outside driver, then the pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         level[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : (last[i] !== 1'b1);
      end
   end
endmodule

// [testbench/two_port_gpio_pin_select_tb_top.sv]
// Self-checking testbench of the two-port general I/O block
module two_port_gpio_pin_select_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] p1_pin_in, p1_pin_out, p1_pin_oe, p1_pullup, p2_pin_in, p2_pin_out, p2_pin_oe, p2_pullup;
   logic [7:0] e1_en = 8'h00, e1_val = 8'h00, e2_en = 8'hff, e2_val = 8'h00;
   logic timer_f_high = 0, timer_f_low = 0, clock_out_src = 0;
   logic [2:0] timer_f_clock_select = 3'h0;
   logic ext_int_one_n, ext_int_two_n, ext_int_three_n, timer_f_event_input, timer_g_capture_input;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   tpg_gpio i_tpg_gpio (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .p1_pin_in, .p1_pin_out, .p1_pin_oe, .p1_pullup, .p2_pin_in, .p2_pin_out,
      .p2_pin_oe, .p2_pullup, .timer_f_high, .timer_f_low, .clock_out_src, .timer_f_clock_select,
      .ext_int_one_n, .ext_int_two_n, .ext_int_three_n, .timer_f_event_input, .timer_g_capture_input);
   tpg_pin_model i_tpg_pin_model (.aclk, .oe(p1_pin_oe), .out(p1_pin_out), .pu(p1_pullup),
      .ext_en(e1_en), .ext_val(e1_val), .level(p1_pin_in));
   tpg_pin_model i_tpg_pin_model_p2 (.aclk, .oe(p2_pin_oe), .out(p2_pin_out), .pu(p2_pullup),
      .ext_en(e2_en), .ext_val(e2_val), .level(p2_pin_in));
   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   always #5 aclk = ~aclk;
   // The whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bus write: address and data offered together, each dropped once taken
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, s_axi_bresp});
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", {24'h00_0000, exp}, s_axi_rdata);
      chk("rresp", {30'h0000_0000, er}, {30'h0000_0000, s_axi_rresp});
   endtask
   // Lets the synchronisers and pin registers catch up
   task automatic settle();
      repeat (4) @(posedge aclk);
      #1;
   endtask
   task automatic final_report();
      $display("Checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      chk("p1_pullup", 8'h00, p1_pullup);
      chk("p1_oe", 8'h00, p1_pin_oe);
      rd(tpg_pkg::IDX_P2_MODE, 8'h40, tpg_pkg::RESP_OKAY);
      rd(tpg_pkg::IDX_P6_MODE, 8'hf8, tpg_pkg::RESP_OKAY);
      rd(tpg_pkg::IDX_P2_PU, 8'h00, tpg_pkg::RESP_OKAY);
      rd(tpg_pkg::IDX_P1_DIR, 8'hff, tpg_pkg::RESP_OKAY);
      rd(16'hff00, 8'h00, tpg_pkg::RESP_SLVERR);
      wr(16'hff01, 8'h55, tpg_pkg::RESP_SLVERR);
      // Port 2: stored bits on outputs, live levels on inputs, pin 7 never drives
      wr(tpg_pkg::IDX_P2_DIR, 8'hff, tpg_pkg::RESP_OKAY);
      rd(tpg_pkg::IDX_P2_DATA, 8'h00, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P2_DATA, 8'ha5, tpg_pkg::RESP_OKAY);
      settle();
      chk("p2_oe", 8'h7f, p2_pin_oe);
      chk("p2_out", 8'h25, p2_pin_out);
      wr(tpg_pkg::IDX_P2_DIR, 8'h0f, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P2_PU, 8'hff, tpg_pkg::RESP_OKAY);
      e2_en <= 8'hf0;
      e2_val <= 8'h30;
      settle();
      rd(tpg_pkg::IDX_P2_DATA, 8'h35, tpg_pkg::RESP_OKAY);
      chk("p2_pullup", 8'h70, p2_pullup);
      // Port 1 general I/O and pull-ups
      wr(tpg_pkg::IDX_P1_DIR, 8'h0f, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P1_DATA, 8'h05, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P1_PU, 8'hff, tpg_pkg::RESP_OKAY);
      e1_en <= 8'hf0;
      e1_val <= 8'ha0;
      settle();
      chk("p1_oe", 8'h0f, p1_pin_oe);
      chk("p1_out", 8'h05, p1_pin_out & p1_pin_oe);
      chk("p1_pullup", 8'hf0, p1_pullup);
      rd(tpg_pkg::IDX_P1_DATA, 8'ha5, tpg_pkg::RESP_OKAY);
      // Timer outputs drive whatever the direction holds
      timer_f_high <= 1'b1;
      clock_out_src <= 1'b1;
      wr(tpg_pkg::IDX_P1_DIR, 8'h00, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P1_MODE, 8'h07, tpg_pkg::RESP_OKAY);
      settle();
      chk("p1_oe", 8'h07, p1_pin_oe);
      chk("p1_out", 8'h05, p1_pin_out & p1_pin_oe);
      // Alternate inputs ignore an output direction
      wr(tpg_pkg::IDX_P1_DIR, 8'hff, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P1_MODE, 8'he8, tpg_pkg::RESP_OKAY);
      // Pin 7 serves as timer F event here, so software keeps interrupt 3 masked
      e1_en <= 8'he8;
      e1_val <= 8'hc0;
      settle();
      chk("p1_oe", 8'h17, p1_pin_oe);
      chk("alt_in", 5'b11010, {ext_int_three_n, ext_int_two_n, ext_int_one_n,
         timer_f_event_input, timer_g_capture_input});
      // Internal timer clock: pin 7 still feeds interrupt 3 but no longer the timer event
      timer_f_clock_select <= 3'h4;
      e1_val <= 8'h40;
      settle();
      chk("alt_in", 5'b01010, {ext_int_three_n, ext_int_two_n, ext_int_one_n,
         timer_f_event_input, timer_g_capture_input});
      // Sleep freezes the pins, standby floats them but keeps pull-ups
      wr(tpg_pkg::IDX_PWR, 8'h04, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P1_DIR, 8'h00, tpg_pkg::RESP_OKAY);
      settle();
      chk("p1_oe", 8'h17, p1_pin_oe);
      wr(tpg_pkg::IDX_PWR, 8'h20, tpg_pkg::RESP_OKAY);
      settle();
      chk("p1_oe", 8'h00, p1_pin_oe);
      chk("p1_pullup", 8'hff, p1_pullup);
      // Watch keeps the standby state even when the pull-up bits are cleared
      wr(tpg_pkg::IDX_PWR, 8'h10, tpg_pkg::RESP_OKAY);
      wr(tpg_pkg::IDX_P1_PU, 8'h00, tpg_pkg::RESP_OKAY);
      settle();
      chk("p1_pullup", 8'hff, p1_pullup);
      final_report();
   end
endmodule
